// ---- include/rit_bus_if.sv ----
// rit_bus_if: decoded host access between top and timer core
// assumes strobes are single-cycle and on i_clk
interface rit_bus_if;
   logic       wr;
   logic       rd;
   logic [1:0] a_low;
   logic       tie;
   logic [7:0] wdata;
   logic [7:0] count;
   logic       expire;
   modport ctl (output wr, output rd, output a_low, output tie, output wdata, input count, input expire);
   modport tmr (input wr, input rd, input a_low, input tie, input wdata, output count, output expire);
endinterface

// ---- include/rit_pkg.sv ----
// rit_pkg: constants shared by the ram/io/timer peripheral and its bus interface
// assumes a single 100 MHz clock domain
package rit_pkg;
   localparam int RAM_DEPTH      = 128;
   localparam int ADDR_W         = 7;
   // port register select (a1,a0) with timer select low
   localparam logic [1:0] SEL_PA_DATA = 2'h0;
   localparam logic [1:0] SEL_PA_DIR  = 2'h1;
   localparam logic [1:0] SEL_PB_DATA = 2'h2;
   localparam logic [1:0] SEL_PB_DIR  = 2'h3;
   // address bit positions
   localparam int BIT_TIMER_SEL  = 2;
   localparam int BIT_TIE        = 3;
   localparam int BIT_TWR        = 4;
   // prescale shift per selection: 1, 8, 64, 1024
   localparam logic [3:0] SHIFT_1    = 4'h0;
   localparam logic [3:0] SHIFT_8    = 4'h3;
   localparam logic [3:0] SHIFT_64   = 4'h6;
   localparam logic [3:0] SHIFT_1024 = 4'hA;
   localparam int PRE_W          = 10;
   // flag register bits
   localparam int FLAG_TIMER_BIT = 7;
   localparam int FLAG_EDGE_BIT  = 6;
   // reset values
   localparam logic [7:0] RST_PORT   = 8'h00;
   localparam logic [7:0] RST_COUNT  = 8'hFF;
   localparam logic [3:0] RST_SHIFT  = 4'h0;
   localparam int SYNC_STAGES    = 3;
endpackage

// ---- rtl/rit_timer.sv ----
// rit_timer: 8-bit interval counter with prescaler
// assumes wr/rd are one-cycle access strobes from the top module
module rit_timer (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   rit_bus_if.tmr    bus
);
   logic [7:0]              count_ff;
   logic [3:0]              shift_ff;
   logic [rit_pkg::PRE_W-1:0] pre_ff;
   logic                    expired_ff;
   logic                    tick;
   logic [rit_pkg::PRE_W-1:0] pre_max;

   function automatic logic [3:0] shift_of(input logic [1:0] sel);
      case (sel)
         2'h0:    shift_of = rit_pkg::SHIFT_1;
         2'h1:    shift_of = rit_pkg::SHIFT_8;
         2'h2:    shift_of = rit_pkg::SHIFT_64;
         default: shift_of = rit_pkg::SHIFT_1024;
      endcase
   endfunction

   // last prescaler value of one interval for a given shift
   function automatic logic [rit_pkg::PRE_W-1:0] top_of(input logic [3:0] sh);
      logic [10:0] full;
      full   = (11'h1 << sh) - 11'h1;
      top_of = full[rit_pkg::PRE_W-1:0];
   endfunction

   assign pre_max = top_of(shift_ff);
   // after expiry count every clock
   assign tick = expired_ff || (pre_ff == pre_max); // RULE19
   assign bus.count = count_ff; // RULE17
   assign bus.expire = tick && !bus.wr && (count_ff == 8'h00) && !expired_ff; // RULE18

   // load count and prescale on write
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count_ff <= rit_pkg::RST_COUNT;
         shift_ff <= rit_pkg::RST_SHIFT;
         pre_ff   <= '0;
      end else if (bus.wr) begin
         count_ff <= bus.wdata; // RULE11
         shift_ff <= shift_of(bus.a_low); // RULE12
         // preset so the first count lands one clock after the write
         pre_ff   <= top_of(shift_of(bus.a_low)); // RULE20
      end else begin
         pre_ff <= (tick || pre_ff == pre_max) ? '0 : pre_ff + 1'b1;
         if (tick)
            count_ff <= count_ff - 8'h01; // RULE18 RULE20
      end
   end

   // post-expiry fast count mode
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         expired_ff <= 1'b0;
      else if (bus.wr)
         expired_ff <= 1'b0;
      else if (bus.expire)
         expired_ff <= 1'b1; // RULE19
   end
endmodule

// ---- rtl/rit_top.sv ----
// rit_top: 128-byte ram, two 8-bit ports, interval timer and interrupt logic
// assumes host bus signals are synchronous to i_clk; port pins are asynchronous
//
// Contract
// RULE1: r/w high reads, low writes when selected
// RULE2: interrupt output is open drain
// RULE3: only edge or timer expiry raise interrupt
// RULE4: data bus driven only during selected read
// RULE5: direction bit 0 input, 1 output
// RULE6: output pins driven from output register
// RULE7: port a read returns pin levels
// RULE8: port b read returns output register
// RULE9: input pins idle high with weak pull-up
// RULE10: 128x8 ram selected by select lines
// RULE11: timer write loads eight-bit count
// RULE12: a1,a0 choose prescale on timer write
// RULE13: a3 latched as timer interrupt enable
// RULE14: expiry sets flag bit 7, enable gates
// RULE15: timer access clears timer flag
// RULE16: read during expiry keeps flag set
// RULE17: read before expiry gives remaining count
// RULE18: zero then next tick expires, wraps ones
// RULE19: after expiry decrement every clock
// RULE20: expiry after count times interval plus one
// RULE21: reset clears ports, interrupts, floats bus
// RULE22: a2 picks ports or timer; a1,a0 register
// RULE23: write needs a4; reads by a0
// RULE24: flags: bit 7 timer, bit 6 edge
// RULE25: interrupt low when enabled flag set
module rit_top (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_read_not_write,
   input  wire logic                        i_chip_select_high,
   input  wire logic                        i_chip_select_low_n,
   input  wire logic                        i_register_or_memory_select_n,
   input  wire logic [rit_pkg::ADDR_W-1:0]  i_address_lines,
   input  wire logic [7:0]                  i_data,
   output logic      [7:0]                  o_data,
   output logic                             o_data_oe,
   output logic                             o_irq_n,
   output logic                             o_irq_oe,
   input  wire logic [7:0]                  i_port_a_pins,
   output logic      [7:0]                  o_port_a_pins,
   output logic      [7:0]                  o_port_a_pins_oe,
   input  wire logic [7:0]                  i_port_b_pins,
   output logic      [7:0]                  o_port_b_pins,
   output logic      [7:0]                  o_port_b_pins_oe,
   output logic      [7:0]                  o_pullup_en
);
   rit_bus_if tbus ();

   logic [7:0] mem [rit_pkg::RAM_DEPTH];
   logic [7:0] port_a_direction_ff;
   logic [7:0] port_b_direction_ff;
   logic [7:0] port_a_output_ff;
   logic [7:0] port_b_output_ff;
   logic [7:0] pa_s1_ff;
   logic [7:0] pa_s2_ff;
   logic [7:0] pa_s3_ff;
   logic [7:0] pa_level_ff;
   logic       edge_prev_ff;
   logic       edge_pos_ff;
   logic       edge_ie_ff;
   logic       edge_flag_ff;
   logic       timer_flag_ff;
   logic       timer_ie_ff;
   logic       sel;
   logic       ram_sel;
   logic       io_sel;
   logic       wr;
   logic       rd;
   logic       tmr_wr;
   logic       tmr_rd;
   logic       flag_rd;
   logic       edge_wr;
   logic       port_wr;
   logic       port_rd;
   logic       edge_hit;
   logic [7:0] nxt_rdata;
   logic [1:0] a_low;

   // chip selection and operation decode
   assign sel     = i_chip_select_high && !i_chip_select_low_n;
   assign ram_sel = sel && !i_register_or_memory_select_n; // RULE10
   assign io_sel  = sel && i_register_or_memory_select_n; // RULE22
   assign wr      = !i_read_not_write; // RULE1
   assign rd      = i_read_not_write; // RULE1
   assign a_low   = i_address_lines[1:0];
   assign port_wr = io_sel && wr && !i_address_lines[rit_pkg::BIT_TIMER_SEL]; // RULE22
   assign port_rd = io_sel && rd && !i_address_lines[rit_pkg::BIT_TIMER_SEL]; // RULE22
   assign tmr_wr  = io_sel && wr && i_address_lines[rit_pkg::BIT_TIMER_SEL]
                    && i_address_lines[rit_pkg::BIT_TWR]; // RULE23
   assign edge_wr = io_sel && wr && i_address_lines[rit_pkg::BIT_TIMER_SEL]
                    && !i_address_lines[rit_pkg::BIT_TWR];
   assign tmr_rd  = io_sel && rd && i_address_lines[rit_pkg::BIT_TIMER_SEL] && !a_low[0]; // RULE23
   assign flag_rd = io_sel && rd && i_address_lines[rit_pkg::BIT_TIMER_SEL] && a_low[0]; // RULE23

   assign tbus.wr    = tmr_wr;
   assign tbus.rd    = tmr_rd;
   assign tbus.a_low = a_low;
   assign tbus.tie   = i_address_lines[rit_pkg::BIT_TIE];
   assign tbus.wdata = i_data;

   rit_timer u_timer (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .bus     (tbus)
   );

   // ram array
   always_ff @(posedge i_clk) begin
      if (ram_sel && wr)
         mem[i_address_lines] <= i_data; // RULE10
   end

   // port a output register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         port_a_output_ff <= rit_pkg::RST_PORT; // RULE21
      else if (port_wr && a_low == rit_pkg::SEL_PA_DATA)
         port_a_output_ff <= i_data; // RULE6
   end

   // port a direction register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         port_a_direction_ff <= rit_pkg::RST_PORT; // RULE21
      else if (port_wr && a_low == rit_pkg::SEL_PA_DIR)
         port_a_direction_ff <= i_data; // RULE5
   end

   // port b output register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         port_b_output_ff <= rit_pkg::RST_PORT; // RULE21
      else if (port_wr && a_low == rit_pkg::SEL_PB_DATA)
         port_b_output_ff <= i_data; // RULE8
   end

   // port b direction register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         port_b_direction_ff <= rit_pkg::RST_PORT; // RULE21
      else if (port_wr && a_low == rit_pkg::SEL_PB_DIR)
         port_b_direction_ff <= i_data; // RULE5
   end

   // port a pins: outputs from register, inputs driver high with pull-up
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_port_a_pins    <= 8'hFF;
         o_port_a_pins_oe <= 8'h00;
         o_pullup_en      <= 8'hFF;
      end else begin
         o_port_a_pins    <= port_a_output_ff | ~port_a_direction_ff; // RULE6 RULE9
         o_port_a_pins_oe <= port_a_direction_ff; // RULE5
         o_pullup_en      <= ~port_a_direction_ff; // RULE9
      end
   end

   // port b pins: same scheme as port a, except no pull-up enable output
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_port_b_pins    <= 8'hFF;
         o_port_b_pins_oe <= 8'h00;
      end else begin
         o_port_b_pins    <= port_b_output_ff | ~port_b_direction_ff; // RULE6 RULE9
         o_port_b_pins_oe <= port_b_direction_ff; // RULE5
      end
   end

   // port a pin synchroniser, three stages
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pa_s1_ff <= 8'hFF;
         pa_s2_ff <= 8'hFF;
         pa_s3_ff <= 8'hFF;
      end else begin
         pa_s1_ff <= i_port_a_pins;
         pa_s2_ff <= pa_s1_ff;
         pa_s3_ff <= pa_s2_ff;
      end
   end

   // per-bit level changes once stages 2 and 3 agree
   for (genvar g = 0; g < 8; g++) begin : g_level
      always_ff @(posedge i_clk) begin
         if (!i_rst_n)
            pa_level_ff[g] <= 1'b1;
         else if (pa_s2_ff[g] == pa_s3_ff[g])
            pa_level_ff[g] <= pa_s3_ff[g]; // RULE7
      end
   end

   // edge detect control on top port a bit
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         edge_ie_ff  <= 1'b0; // RULE21
         edge_pos_ff <= 1'b0;
      end else if (edge_wr) begin
         edge_ie_ff  <= a_low[1];
         edge_pos_ff <= a_low[0];
      end
   end

   assign edge_hit = edge_pos_ff ? (pa_level_ff[7] && !edge_prev_ff)
                                 : (!pa_level_ff[7] && edge_prev_ff);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         edge_prev_ff <= 1'b1;
      else
         edge_prev_ff <= pa_level_ff[7];
   end

   // edge flag: set wins over read clear
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         edge_flag_ff <= 1'b0;
      else if (edge_hit)
         edge_flag_ff <= 1'b1; // RULE3
      else if (flag_rd)
         edge_flag_ff <= 1'b0; // RULE24
   end

   // timer flag: expiry wins over access clear
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         timer_flag_ff <= 1'b0;
      else if (tbus.expire)
         timer_flag_ff <= 1'b1; // RULE14 RULE16
      else if (tmr_wr || tmr_rd)
         timer_flag_ff <= 1'b0; // RULE15
   end

   // timer interrupt enable latched from a3
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         timer_ie_ff <= 1'b0; // RULE21
      else if (tmr_wr || tmr_rd)
         timer_ie_ff <= tbus.tie; // RULE13
   end

   // interrupt output, open drain
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_irq_n  <= 1'b0;
         o_irq_oe <= 1'b0;
      end else begin
         o_irq_n  <= 1'b0; // RULE2
         o_irq_oe <= (timer_flag_ff && timer_ie_ff) || (edge_flag_ff && edge_ie_ff); // RULE3 RULE14 RULE25
      end
   end

   // read mux
   always_comb begin
      nxt_rdata = 8'h00;
      if (ram_sel)
         nxt_rdata = mem[i_address_lines];
      else if (port_rd) begin
         case (a_low)
            rit_pkg::SEL_PA_DATA: nxt_rdata = pa_level_ff; // RULE7
            rit_pkg::SEL_PA_DIR:  nxt_rdata = port_a_direction_ff;
            rit_pkg::SEL_PB_DATA: nxt_rdata = port_b_output_ff; // RULE8
            default:              nxt_rdata = port_b_direction_ff;
         endcase
      end else if (tmr_rd)
         nxt_rdata = tbus.count; // RULE17
      else if (flag_rd) begin
         nxt_rdata[rit_pkg::FLAG_TIMER_BIT] = timer_flag_ff; // RULE24
         nxt_rdata[rit_pkg::FLAG_EDGE_BIT]  = edge_flag_ff;
      end
   end

   // data bus driven one cycle after a selected read
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_data    <= 8'h00;
         o_data_oe <= 1'b0; // RULE21
      end else begin
         o_data    <= nxt_rdata;
         o_data_oe <= sel && rd; // RULE4
      end
   end
endmodule

// ---- tb/rit_host.sv ----
// rit_host: host processor bus model
// assumes calls start at a falling edge
module rit_host (
   input  wire logic       i_clk,
   output logic            o_rnw,
   output logic            o_cs_h,
   output logic            o_cs_l_n,
   output logic            o_rs_n,
   output logic [6:0]      o_addr,
   output logic [7:0]      o_wdata,
   input  wire logic [7:0] i_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_rnw = 1'b1;
      o_rs_n = 1'b0;
      o_addr = 7'h00;
      o_wdata = 8'h00;
      idle();
   end
   // one access; selection stays up until idle
   task automatic acc(input logic rnw, rs, s, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      o_rnw = rnw;
      o_rs_n = rs;
      o_addr = a;
      o_wdata = d;
      o_cs_h = s;
      o_cs_l_n = 1'b0;
      @(negedge i_clk);
      q = i_rdata;
   endtask
   task automatic idle();
      o_cs_h = 1'b0;
      o_cs_l_n = 1'b1;
      o_wdata = ~o_wdata;
   endtask
endmodule

// ---- tb/rit_sva.sv ----
// rit_sva: port checks for rit_top
// assumes the edge interrupt stays disabled
module rit_sva (
   input wire logic                       i_clk,
   input wire logic                       i_rst_n,
   input wire logic                       i_read_not_write,
   input wire logic                       i_chip_select_high,
   input wire logic                       i_chip_select_low_n,
   input wire logic                       i_register_or_memory_select_n,
   input wire logic [rit_pkg::ADDR_W-1:0] i_address_lines,
   input wire logic [7:0]                 i_data,
   input wire logic                       o_data_oe,
   input wire logic                       o_irq_n,
   input wire logic                       o_irq_oe,
   input wire logic [7:0]                 o_port_a_pins,
   input wire logic [7:0]                 o_port_a_pins_oe,
   input wire logic [7:0]                 o_port_b_pins,
   input wire logic [7:0]                 o_port_b_pins_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire sel = i_chip_select_high && !i_chip_select_low_n;
   wire twr = sel && i_register_or_memory_select_n && !i_read_not_write
              && i_address_lines[4] && i_address_lines[2];
   // timer write of count 2 at prescale 1
   sequence s_go(bit en);
      twr && i_address_lines[3] == en && i_address_lines[1:0] == 2'h0 && i_data == 8'h02;
   endsequence
   sequence s_quiet;
      !sel [*8];
   endsequence
   a_bus_float: assert property (o_data_oe |-> $past(sel && i_read_not_write))
      else $error("data bus driven without read");
   a_read_drive: assert property (sel && i_read_not_write |=> o_data_oe)
      else $error("read not answered");
   a_idle_high: assert property ((~o_port_a_pins_oe & ~o_port_a_pins) == 8'h00)
      else $error("port a input pin not high");
   a_idle_high_b: assert property ((~o_port_b_pins_oe & ~o_port_b_pins) == 8'h00)
      else $error("port b input pin not high");
   a_irq_drain: assert property (o_irq_n == 1'b0)
      else $error("irq drives high");
   a_reset_quiet: assert property (disable iff (1'b0)
      !i_rst_n |=> !o_data_oe && !o_irq_oe && o_port_a_pins_oe == 8'h00)
      else $error("reset left outputs active");
   a_expire_irq: assert property (s_go(1'b1) ##1 s_quiet |-> o_irq_oe)
      else $error("timer irq missing");
   a_expire_early: assert property (s_go(1'b1) |-> ##3 !o_irq_oe [*2])
      else $error("timer irq too early");
   a_tie_gate: assert property (s_go(1'b0) ##1 s_quiet |-> !o_irq_oe)
      else $error("disabled timer irq asserted");
endmodule
bind rit_top rit_sva u_sva (.*);

// ---- tb/testbench.sv ----
// testbench: self-checking bench for rit_top
// assumes rit_host drives the bus
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       rnw, csh, csl_n, rs_n, do_oe, irq_n, irq_oe;
   logic [6:0] adr;
   logic [7:0] wd, dq, pa_in, pa, pa_oe, pb, pb_oe, pu, q, q2;
   int         n_errors = 0;
   int         n_tests = 0;
   int         n, c;
   always #5 clk = ~clk;
   rit_host host (.i_clk(clk), .o_rnw(rnw), .o_cs_h(csh), .o_cs_l_n(csl_n), .o_rs_n(rs_n),
                  .o_addr(adr), .o_wdata(wd), .i_rdata(dq));
   rit_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_read_not_write(rnw), .i_chip_select_high(csh),
      .i_chip_select_low_n(csl_n), .i_register_or_memory_select_n(rs_n), .i_address_lines(adr),
      .i_data(wd), .o_data(dq), .o_data_oe(do_oe), .o_irq_n(irq_n), .o_irq_oe(irq_oe),
      .i_port_a_pins(pa_in), .o_port_a_pins(pa), .o_port_a_pins_oe(pa_oe), .i_port_b_pins(~pa_in),
      .o_port_b_pins(pb), .o_port_b_pins_oe(pb_oe), .o_pullup_en(pu));
   task automatic check(input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic rs, input logic [6:0] a, input logic [7:0] d);
      host.acc(1'b0, rs, 1'b1, a, d, q);
      host.idle();
      @(negedge clk);
   endtask
   task automatic rd(input logic rs, input logic [6:0] a);
      host.acc(1'b1, rs, 1'b1, a, 8'h00, q);
      host.idle();
      @(negedge clk);
   endtask
   task automatic t_reset();
      check({do_oe, irq_oe}, 8'h00);
      check(pa_oe | pb_oe, 8'h00);
      check(pa & pb & pu, 8'hFF);
   endtask
   task automatic t_ram();
      wr(1'b0, 7'h00, 8'h5A);
      wr(1'b0, 7'h7F, 8'hC3);
      host.acc(1'b0, 1'b0, 1'b0, 7'h7F, 8'h00, q);
      host.idle();
      @(negedge clk);
      rd(1'b0, 7'h00);
      check(q, 8'h5A);
      rd(1'b0, 7'h7F);
      check(q, 8'hC3);
   endtask
   task automatic t_ports();
      wr(1'b1, 7'h01, 8'h0F);
      wr(1'b1, 7'h00, 8'hA5);
      wr(1'b1, 7'h03, 8'hF0);
      wr(1'b1, 7'h02, 8'h3C);
      pa_in = 8'h96;
      repeat (6) @(negedge clk);
      check(pa_oe, 8'h0F);
      check(pa, 8'hF5);
      check(pb, 8'h3F);
      rd(1'b1, 7'h03);
      check(q, 8'hF0);
      rd(1'b1, 7'h02);
      check(q, 8'h3C);
      rd(1'b1, 7'h00);
      check(q, 8'h96);
      check(pb_oe, 8'hF0);
      check(pu, 8'hF0);
      rd(1'b1, 7'h05);
      check(q[6], 8'h01);
      rd(1'b1, 7'h05);
      check(q[6], 8'h00);
   endtask
   task automatic t_expire(input logic [1:0] p);
      c = (p == 2'h3) ? 2048 : 2 << (3 * p);
      wr(1'b1, {2'b00, 1'b1, p[0], 1'b1, p}, 8'h02);
      n = 0;
      do begin
         host.acc(1'b1, 1'b1, 1'b1, 7'h05, 8'h00, q);
         n++;
      end while (!q[7] && n < 3000);
      host.idle();
      check(n >= c && n <= c + 2, 8'h01);
      repeat (2) @(negedge clk);
      check(irq_oe, p[0]);
      rd(1'b1, 7'h04);
      check(q inside {[8'hF8:8'hFD]}, 8'h01);
      repeat (2) @(negedge clk);
      check(irq_oe, 8'h00);
      rd(1'b1, 7'h05);
      check(q[7], 8'h00);
   endtask
   task automatic t_count();
      wr(1'b1, 7'h14, 8'h28);
      host.acc(1'b1, 1'b1, 1'b1, 7'h04, 8'h00, q2);
      host.acc(1'b1, 1'b1, 1'b1, 7'h04, 8'h00, q);
      host.idle();
      @(negedge clk);
      check(q2 - q, 8'h01);
      check(q2 inside {[8'd36:8'd40]}, 8'h01);
   endtask
   task automatic t_irq(input logic en);
      wr(1'b1, {3'b101, en, 3'b100}, 8'h02);
      repeat (10) @(negedge clk);
      check(irq_oe, en);
      rd(1'b1, 7'h04);
   endtask
   task automatic stop_test();
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      pa_in = 8'h00;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_reset();
      t_ram();
      t_ports();
      for (int p = 0; p < 4; p++) t_expire(p[1:0]);
      t_count();
      t_irq(1'b0);
      t_irq(1'b1);
      stop_test();
   end
   initial begin
      #200us;
      n_errors++;
      stop_test();
   end
endmodule
